/* File: sfe_pkg.sv */
package sfe_pkg;
   // ==========================================================
   // timing
   localparam int CLK_MHZ = 25;
   localparam int SECTOR_ERASE_NS = 100000;
   localparam int BLOCK32_ERASE_NS = 200000;
   localparam int BLOCK64_ERASE_NS = 300000;
   localparam int ARRAY_ERASE_TIME_NS = 800000;
   localparam int SLEEP_ENTRY_NS = 3000;
   localparam int WAKE_TIME_PLAIN_NS = 3000;
   localparam int WAKE_TIME_WITH_ID_NS = 2000;
   localparam int SCLK_HALF_DEFAULT = 4;
   localparam int CS_GAP_CYC = 8;

   // least times round up to whole cycles, never below one
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cyc

   localparam int SECTOR_ERASE_CYC = ns_to_cyc(SECTOR_ERASE_NS);
   localparam int BLOCK32_ERASE_CYC = ns_to_cyc(BLOCK32_ERASE_NS);
   localparam int BLOCK64_ERASE_CYC = ns_to_cyc(BLOCK64_ERASE_NS);
   localparam int ARRAY_ERASE_CYC = ns_to_cyc(ARRAY_ERASE_TIME_NS);
   localparam int SLEEP_ENTRY_CYC = ns_to_cyc(SLEEP_ENTRY_NS);
   localparam int WAKE_PLAIN_CYC = ns_to_cyc(WAKE_TIME_PLAIN_NS);
   localparam int WAKE_ID_CYC = ns_to_cyc(WAKE_TIME_WITH_ID_NS);

   // ==========================================================
   // opcodes and frame lengths
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
   localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
   localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
   localparam logic [7:0] OP_WAKE_ID = 8'hab;
   localparam logic [5:0] BITS_OPCODE = 6'h08;
   localparam logic [5:0] BITS_ADDR_CMD = 6'h20;
   localparam logic [5:0] BITS_READ = 6'h08;
   localparam logic [5:0] BITS_SAT = 6'h3f;
   localparam logic [2:0] OUT_MSB = 3'h7;
   localparam int STAT_WIP_BIT = 0;
   localparam int STAT_WEL_BIT = 1;
   localparam logic [4:0] BP_NONE = 5'h00;
   localparam logic [23:0] SECTOR_MASK = 24'h000fff;
   localparam logic [23:0] BLOCK32_MASK = 24'h007fff;
   localparam logic [23:0] BLOCK64_MASK = 24'h00ffff;
   localparam logic [7:0] DEVICE_ID_DEFAULT = 8'h5a; // arbitrary value

   typedef enum logic [1:0] {
      ERASE_SECTOR = 2'h0,
      ERASE_BLOCK32 = 2'h1,
      ERASE_BLOCK64 = 2'h2,
      ERASE_CHIP = 2'h3
   } sfe_erase_kind_t;

   // ==========================================================
   // host register map
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam int CMD_WITH_ID_BIT = 8;
   localparam int STATUS_BUSY_BIT = 0;
endpackage : sfe_pkg

/* File: sfe_link_if.sv */
`timescale 1ns/1ps
interface sfe_link_if;
   logic cs_n;
   logic sclk;
   logic si;
   logic so;
   modport device (input cs_n, input sclk, input si, output so);
   modport host (output cs_n, output sclk, output si, input so);
endinterface : sfe_link_if

/* File: sfe_device.sv */
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// (R1) 20h plus three address bytes erases sector
// (R2) 52h plus three address bytes erases 32KB
// (R3) d8h plus three address bytes erases 64KB
// (R4) 60h or c7h alone erases whole array
// (R5) erase needs write enable latch set first
// (R6) address erase: select rises after bit 32
// (R7) opcode-only: select rises right after bit 8
// (R8) erase starts at select rise; busy flag
// (R9) latch cleared before erase cycle ends
// (R10) status reads served during erase
// (R11) protected sector or block is not erased
// (R12) chip erase only with no protect bits
// (R13) deep sleep entered only by b9h
// (R14) deep sleep ignores all but abh
// (R15) deep sleep begins after entry delay
// (R16) sleep request during erase is rejected
// (R17) reset always lands in standby
// (R18) standby only when no cycle runs
// (R19) abh alone wakes; wait plain wake time
// (R20) abh, dummies, then id repeated msb first
// (R21) host waits id wake time after id wake
// (R22) abh ignored while erase is running
// (R23) erase ignored while write latch clear
module sfe_device #(
   parameter int SECTOR_CYC = sfe_pkg::SECTOR_ERASE_CYC,
   parameter int BLOCK32_CYC = sfe_pkg::BLOCK32_ERASE_CYC,
   parameter int BLOCK64_CYC = sfe_pkg::BLOCK64_ERASE_CYC,
   parameter int CHIP_CYC = sfe_pkg::ARRAY_ERASE_CYC,
   parameter int ENTRY_CYC = sfe_pkg::SLEEP_ENTRY_CYC,
   parameter int WAKE_PLAIN = sfe_pkg::WAKE_PLAIN_CYC,
   parameter int WAKE_ID = sfe_pkg::WAKE_ID_CYC,
   parameter logic [7:0] DEVICE_ID = sfe_pkg::DEVICE_ID_DEFAULT
) (
   input wire logic clk_i, // system clock
   input wire logic reset_n_i, // async reset, active low
   sfe_link_if.device link, // serial link
   input wire logic [4:0] block_protect_i, // protect bits, async
   output logic erase_busy_o, // erase cycle running
   output sfe_pkg::sfe_erase_kind_t erase_kind_o, // kind of last erase
   output logic [23:0] erase_addr_o, // aligned base of last erase
   output logic write_enable_latch_o, // latch state
   output logic deep_sleep_o // in deep power-down
);
   import sfe_pkg::*;

   typedef enum logic [2:0] {
      ST_STANDBY = 3'h0,
      ST_ENTER = 3'h1,
      ST_SLEEP = 3'h3,
      ST_WAKING = 3'h2,
      ST_BUSY = 3'h6
   } sfe_dev_state_t;

   // ==========================================================
   // synchronisers
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;
   logic [2:0] pin_prev;
   logic [4:0] bp_meta;
   logic [4:0] bp_sync;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         // idle levels: select high, clock and data low, so no false
         // clock edge is seen after reset
         pin_meta <= 3'h4;
         pin_sync <= 3'h4;
         pin_prev <= 3'h4;
         bp_meta <= BP_NONE;
         bp_sync <= BP_NONE;
      end else begin
         pin_meta <= {link.cs_n, link.sclk, link.si};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
         bp_meta <= block_protect_i;
         bp_sync <= bp_meta;
      end
   end

   logic cs_high;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   logic si_bit;
   assign cs_high = pin_sync[2];
   assign si_bit = pin_sync[0];
   assign cs_rise = pin_sync[2] & ~pin_prev[2];
   assign sclk_rise = ~cs_high & pin_sync[1] & ~pin_prev[1];
   assign sclk_fall = ~cs_high & ~pin_sync[1] & pin_prev[1];

   // ==========================================================
   // input shifter
   logic [5:0] bits;
   logic [31:0] shift;
   logic [7:0] opcode;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bits <= 6'h00;
         shift <= 32'h0;
         opcode <= 8'h00;
      end else if (cs_high) begin
         bits <= 6'h00;
      end else if (sclk_rise) begin
         shift <= {shift[30:0], si_bit};
         // saturation keeps long frames from aliasing onto bit 8 or 32
         if (bits != BITS_SAT) begin
            bits <= bits + 6'h01;
         end
         if (bits == BITS_OPCODE - 6'h01) begin
            opcode <= {shift[6:0], si_bit};
         end
      end
   end

   // ==========================================================
   // command decode at select rise
   sfe_dev_state_t state;
   logic [31:0] timer;
   logic write_enable_latch;
   logic is_addr_erase;
   logic is_chip_erase;
   logic [23:0] frame_addr;

   assign is_addr_erase = (opcode == OP_SECTOR_ERASE) | // (R1)
      (opcode == OP_BLOCK32_ERASE) | // (R2)
      (opcode == OP_BLOCK64_ERASE); // (R3)
   assign is_chip_erase = (opcode == OP_CHIP_ERASE_A) |
      (opcode == OP_CHIP_ERASE_B); // (R4)
   assign frame_addr = shift[23:0];

   // protect decoding is whole-array: any set bit guards every region
   function automatic logic region_protected(input logic [4:0] bp);
      return bp != BP_NONE;
   endfunction : region_protected

   function automatic logic [31:0] erase_len(input logic [7:0] op);
      case (op)
         OP_SECTOR_ERASE: erase_len = 32'(SECTOR_CYC - 1);
         OP_BLOCK32_ERASE: erase_len = 32'(BLOCK32_CYC - 1);
         OP_BLOCK64_ERASE: erase_len = 32'(BLOCK64_CYC - 1);
         default: erase_len = 32'(CHIP_CYC - 1);
      endcase
   endfunction : erase_len

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= ST_STANDBY; // (R17)
         timer <= 32'h0;
         write_enable_latch <= 1'b0;
         erase_kind_o <= ERASE_SECTOR;
         erase_addr_o <= 24'h0;
      end else begin
         case (state)
            ST_STANDBY: begin
               if (cs_rise && bits == BITS_OPCODE &&
                   opcode == OP_WRITE_ENABLE) begin
                  write_enable_latch <= 1'b1;
               end else if (cs_rise && bits == BITS_ADDR_CMD && // (R6)
                            is_addr_erase && write_enable_latch && // (R5) (R23)
                            !region_protected(bp_sync)) begin // (R11)
                  state <= ST_BUSY; // (R8)
                  timer <= erase_len(opcode);
                  write_enable_latch <= 1'b0; // (R9)
                  case (opcode)
                     OP_SECTOR_ERASE: begin
                        erase_kind_o <= ERASE_SECTOR;
                        erase_addr_o <= frame_addr & ~SECTOR_MASK; // (R1)
                     end
                     OP_BLOCK32_ERASE: begin
                        erase_kind_o <= ERASE_BLOCK32;
                        erase_addr_o <= frame_addr & ~BLOCK32_MASK; // (R2)
                     end
                     default: begin
                        erase_kind_o <= ERASE_BLOCK64;
                        erase_addr_o <= frame_addr & ~BLOCK64_MASK; // (R3)
                     end
                  endcase
               end else if (cs_rise && bits == BITS_OPCODE && // (R7)
                            is_chip_erase && write_enable_latch && // (R5) (R23)
                            bp_sync == BP_NONE) begin // (R12)
                  state <= ST_BUSY; // (R8)
                  timer <= erase_len(opcode);
                  write_enable_latch <= 1'b0; // (R9)
                  erase_kind_o <= ERASE_CHIP; // (R4)
                  erase_addr_o <= 24'h0;
               end else if (cs_rise && bits == BITS_OPCODE && // (R7)
                            opcode == OP_DEEP_SLEEP) begin // (R13)
                  state <= ST_ENTER;
                  timer <= 32'(ENTRY_CYC - 1); // (R15)
               end
            end
            ST_BUSY: begin
               // select rises are not decoded here, so sleep and wake
               // requests cannot touch the running cycle
               if (timer == 32'h0) begin // (R16) (R22)
                  state <= ST_STANDBY; // (R18)
               end else begin
                  timer <= timer - 32'h1;
               end
            end
            ST_ENTER: begin
               if (timer == 32'h0) begin
                  state <= ST_SLEEP; // (R15)
               end else begin
                  timer <= timer - 32'h1;
               end
            end
            ST_SLEEP: begin
               // only the wake opcode is decoded in deep sleep
               if (cs_rise && opcode == OP_WAKE_ID) begin // (R14)
                  if (bits == BITS_OPCODE) begin
                     state <= ST_WAKING;
                     timer <= 32'(WAKE_PLAIN - 1); // (R19)
                  end else if (bits >= BITS_ADDR_CMD) begin
                     state <= ST_WAKING;
                     timer <= 32'(WAKE_ID - 1); // (R21)
                  end
               end
            end
            ST_WAKING: begin
               // a frame whose select rises before the wake time ends is simply lost
               if (timer == 32'h0) begin
                  state <= ST_STANDBY; // (R19)
               end else begin
                  timer <= timer - 32'h1;
               end
            end
            default: state <= ST_STANDBY;
         endcase
      end
   end

   // ==========================================================
   // serial output on falling clock edges
   logic [7:0] status_byte;
   logic status_act;
   logic id_act;
   logic [2:0] out_idx;

   always_comb begin
      status_byte = 8'h00;
      status_byte[STAT_WIP_BIT] = (state == ST_BUSY); // (R8)
      status_byte[STAT_WEL_BIT] = write_enable_latch;
   end

   assign status_act = (opcode == OP_READ_STATUS) && // (R10)
      bits >= BITS_OPCODE &&
      (state == ST_STANDBY || state == ST_BUSY); // (R14)
   assign id_act = (opcode == OP_WAKE_ID) && bits >= BITS_ADDR_CMD &&
      (state == ST_STANDBY || state == ST_SLEEP); // (R20) (R22)

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         out_idx <= OUT_MSB;
         link.so <= 1'b0;
      end else if (cs_high) begin
         out_idx <= OUT_MSB;
         link.so <= 1'b0;
      end else if (sclk_fall && (status_act || id_act)) begin
         // index wraps, so the byte repeats until select rises
         link.so <= status_act ? status_byte[out_idx] :
            DEVICE_ID[out_idx]; // (R20)
         out_idx <= out_idx - 3'h1;
      end
   end

   // ==========================================================
   // user-side flags
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         erase_busy_o <= 1'b0;
         write_enable_latch_o <= 1'b0;
         deep_sleep_o <= 1'b0;
      end else begin
         erase_busy_o <= (state == ST_BUSY);
         write_enable_latch_o <= write_enable_latch;
         deep_sleep_o <= (state == ST_SLEEP);
      end
   end
endmodule : sfe_device

/* File: sfe_host.sv */
`timescale 1ns/1ps
module sfe_host #(
   parameter int SCLK_HALF = sfe_pkg::SCLK_HALF_DEFAULT,
   parameter int WAKE_PLAIN = sfe_pkg::WAKE_PLAIN_CYC,
   parameter int WAKE_ID = sfe_pkg::WAKE_ID_CYC
) (
   input wire logic clk_i, // system clock
   input wire logic reset_n_i, // async reset, active low
   sfe_link_if.host link, // serial link
   input wire logic [7:0] addr_i, // register byte address
   input wire logic [31:0] wdata_i, // write data
   input wire logic wr_i, // write strobe
   input wire logic rd_i, // read strobe
   output logic [31:0] rdata_o // read data, cycle after strobe
);
   import sfe_pkg::*;

   // the select gap never drops below the normal frame spacing
   function automatic logic [31:0] hold_cyc(input int t);
      return 32'((t > CS_GAP_CYC) ? t : CS_GAP_CYC);
   endfunction : hold_cyc

   typedef enum logic [1:0] {
      HS_IDLE = 2'h0,
      HS_SHIFT = 2'h1,
      HS_GAP = 2'h3
   } sfe_host_state_t;

   sfe_host_state_t state;
   logic [23:0] addr_reg;
   logic [7:0] rx_byte;
   logic [31:0] shift;
   logic [5:0] done;
   logic [5:0] tx_bits;
   logic [5:0] total;
   logic [31:0] cnt;
   logic [31:0] gap_len;
   logic so_meta;
   logic so_sync;
   logic start;
   logic with_id;
   logic [7:0] op;
   logic addr_op;

   assign start = wr_i && addr_i == REG_CMD && state == HS_IDLE;
   assign op = wdata_i[7:0];
   assign with_id = wdata_i[CMD_WITH_ID_BIT] && op == OP_WAKE_ID;
   assign addr_op = op == OP_SECTOR_ERASE || op == OP_BLOCK32_ERASE ||
      op == OP_BLOCK64_ERASE;

   // ==========================================================
   // register port
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         addr_reg <= 24'h0;
         rdata_o <= 32'h0;
      end else begin
         if (wr_i && addr_i == REG_ADDR) begin
            addr_reg <= wdata_i[23:0];
         end
         if (rd_i) begin
            case (addr_i)
               REG_ADDR: rdata_o <= {8'h00, addr_reg};
               REG_STATUS: rdata_o <= {16'h0, rx_byte, 7'h00,
                  state != HS_IDLE};
               default: rdata_o <= 32'h0;
            endcase
         end else begin
            rdata_o <= 32'h0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         so_meta <= 1'b0;
         so_sync <= 1'b0;
      end else begin
         so_meta <= link.so;
         so_sync <= so_meta;
      end
   end

   // ==========================================================
   // frame engine: mode 0, data set while clock low
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= HS_IDLE;
         link.cs_n <= 1'b1;
         link.sclk <= 1'b0;
         link.si <= 1'b0;
         shift <= 32'h0;
         done <= 6'h00;
         tx_bits <= 6'h00;
         total <= 6'h00;
         cnt <= 32'h0;
         gap_len <= 32'h0;
         rx_byte <= 8'h00;
      end else begin
         case (state)
            HS_IDLE: begin
               if (start) begin
                  // sector and block erases carry the address; id read sends dummies
                  tx_bits <= (addr_op || with_id) ? BITS_ADDR_CMD :
                     BITS_OPCODE; // (R1) (R2) (R3) (R4) (R20)
                  total <= ((addr_op || with_id) ? BITS_ADDR_CMD :
                     BITS_OPCODE) + ((with_id || op == OP_READ_STATUS) ?
                     BITS_READ : 6'h00);
                  shift <= {op, addr_op ? addr_reg : 24'h0};
                  link.si <= op[7];
                  link.cs_n <= 1'b0;
                  done <= 6'h00;
                  // a wake frame keeps select high for the wake time, so
                  // the next frame cannot land while the device is waking
                  if (op == OP_WAKE_ID) begin
                     gap_len <= with_id ? hold_cyc(WAKE_ID) : // (R21)
                        hold_cyc(WAKE_PLAIN); // (R19)
                  end else begin
                     gap_len <= hold_cyc(CS_GAP_CYC);
                  end
                  cnt <= 32'(SCLK_HALF - 1);
                  state <= HS_SHIFT;
               end
            end
            HS_SHIFT: begin
               if (cnt != 32'h0) begin
                  cnt <= cnt - 32'h1;
               end else if (!link.sclk) begin
                  cnt <= 32'(SCLK_HALF - 1);
                  if (done == total) begin
                     // select rises exactly after the last bit
                     link.cs_n <= 1'b1; // (R6) (R7)
                     state <= HS_GAP;
                     cnt <= gap_len; // (R19) (R21)
                  end else begin
                     link.sclk <= 1'b1;
                     done <= done + 6'h01;
                  end
               end else begin
                  cnt <= 32'(SCLK_HALF - 1);
                  link.sclk <= 1'b0;
                  shift <= {shift[30:0], 1'b0};
                  link.si <= shift[30];
                  if (done > tx_bits) begin
                     rx_byte <= {rx_byte[6:0], so_sync}; // (R20)
                  end
               end
            end
            HS_GAP: begin
               if (cnt == 32'h0) begin
                  state <= HS_IDLE;
               end else begin
                  cnt <= cnt - 32'h1;
               end
            end
            default: state <= HS_IDLE;
         endcase
      end
   end

endmodule : sfe_host

/* File: sfe_link_sva.sv */
`timescale 1ns/1ps
module sfe_link_sva (
   input wire logic clk_i, // system clock
   input wire logic reset_n_i, // async reset, active low
   input wire logic cs_n, // link select
   input wire logic sclk, // link clock
   input wire logic si, // host data
   input wire logic so, // device data
   input wire logic erase_busy_o, // erase running
   input wire logic write_enable_latch_o, // write latch
   input wire logic deep_sleep_o // deep sleep
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // ==========================================================
   // wire level
   AST_SO_IDLE: assert property (cs_n [*6] |-> !so)
      else $error("so driven while deselected");
   AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
      else $error("sclk high while deselected");
   AST_SI_STABLE: assert property (sclk && $past(sclk) |-> $stable(si))
      else $error("si moved while sclk high");
   AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*6])
      else $error("select gap too short");
   // ==========================================================
   // device state
   // busy may only follow a finished frame, never open select
   AST_BUSY_AFTER_CS: assert property (
      $rose(erase_busy_o) |-> cs_n && $past(cs_n, 2))
      else $error("erase began without select rise");
   AST_BUSY_NEEDS_WEL: assert property (
      $rose(erase_busy_o) |-> $past(write_enable_latch_o, 3))
      else $error("erase began with latch clear");
   AST_WEL_CLEAR: assert property (
      $rose(erase_busy_o) |-> ##[0:2] !write_enable_latch_o)
      else $error("latch not cleared by erase");
   AST_NO_SLEEP_BUSY: assert property (erase_busy_o |-> !deep_sleep_o)
      else $error("sleep during erase");
   AST_SLEEP_DELAY: assert property (
      $rose(deep_sleep_o) |-> cs_n && $past(cs_n, 8))
      else $error("sleep entered too early");
endmodule : sfe_link_sva

/* File: sfe_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin \
   checks_done++; \
   if ((a) !== (e)) begin \
      mismatches++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); \
   end \
end
module sfe_tb;
   import sfe_pkg::*;
   localparam int SEC = 300;
   localparam int B32 = 350;
   localparam int B64 = 400;
   localparam int CHP = 450;
   localparam int ENT = 40;
   localparam int WAKE = 30;
   localparam logic [7:0] ID = 8'h3c; // arbitrary value
   localparam logic [23:0] A = 24'h123456;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [31:0] rdata;
   logic [31:0] rv;
   logic [4:0] bp = 5'h00;
   logic busy, write_enable_latch, sleep, busy_q;
   sfe_erase_kind_t kind;
   logic [23:0] eaddr;
   logic [7:0] s;
   int mismatches = 0;
   int checks_done = 0;
   int rises = 0;
   int blen = 0;
   int r0;
   logic [7:0] ops [5] = '{OP_SECTOR_ERASE, OP_BLOCK32_ERASE,
      OP_BLOCK64_ERASE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
   sfe_erase_kind_t kinds [5] = '{ERASE_SECTOR, ERASE_BLOCK32,
      ERASE_BLOCK64, ERASE_CHIP, ERASE_CHIP};
   logic [23:0] bases [5] = '{A & ~SECTOR_MASK, A & ~BLOCK32_MASK,
      A & ~BLOCK64_MASK, 24'h0, 24'h0};
   int lens [5] = '{SEC, B32, B64, CHP, CHP};

   always #20 clk_i = ~clk_i;

   sfe_link_if link ();
   sfe_device #(.SECTOR_CYC(SEC), .BLOCK32_CYC(B32), .BLOCK64_CYC(B64),
      .CHIP_CYC(CHP), .ENTRY_CYC(ENT), .WAKE_PLAIN(WAKE), .WAKE_ID(WAKE),
      .DEVICE_ID(ID)) u_sfe_device (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .link(link), .block_protect_i(bp), .erase_busy_o(busy),
      .erase_kind_o(kind), .erase_addr_o(eaddr),
      .write_enable_latch_o(write_enable_latch), .deep_sleep_o(sleep));
   sfe_host #(.WAKE_PLAIN(WAKE), .WAKE_ID(WAKE)) u_sfe_host (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .link(link), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata));
   sfe_link_sva u_sfe_link_sva (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .cs_n(link.cs_n), .sclk(link.sclk), .si(link.si), .so(link.so),
      .erase_busy_o(busy), .write_enable_latch_o(write_enable_latch),
      .deep_sleep_o(sleep));

   // sampled off the edge so design flops have settled
   always @(negedge clk_i) begin
      if (busy === 1'b1 && busy_q !== 1'b1) begin
         rises++;
         blen = 0;
      end
      if (busy === 1'b1) blen++;
      busy_q = busy;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test

   task automatic fail_out();
      mismatches++;
      stop_test();
   endtask : fail_out

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk_i);
      wr_s <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_i);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask : reg_rd

   // one frame, then wait for the host to report it done
   task automatic cmd(input logic [7:0] op, input logic id);
      logic [31:0] d;
      int n;
      reg_wr(REG_ADDR, {8'h00, A});
      reg_wr(REG_CMD, {23'h0, id, op});
      repeat (2) @(posedge clk_i);
      n = 0;
      do begin
         reg_rd(REG_STATUS, d);
         n++;
      end while (d[STATUS_BUSY_BIT] !== 1'b0 && n < 400);
      if (n >= 400) fail_out();
      repeat (CS_GAP_CYC) @(posedge clk_i);
   endtask : cmd

   task automatic stat(output logic [7:0] v);
      logic [31:0] d;
      cmd(OP_READ_STATUS, 1'b0);
      reg_rd(REG_STATUS, d);
      v = d[15:8];
   endtask : stat

   task automatic wait_busy(input logic v, input int n);
      int k;
      k = 0;
      while (busy !== v && k < n) begin
         @(negedge clk_i);
         k++;
      end
      if (busy !== v) fail_out();
   endtask : wait_busy

   task automatic sleep_cycle();
      cmd(OP_DEEP_SLEEP, 1'b0);
      `CHK(sleep, 1'b0);
      repeat (ENT + 20) @(posedge clk_i);
      `CHK(sleep, 1'b1);
   endtask : sleep_cycle

   initial begin
      repeat (4) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      `CHK({write_enable_latch, sleep, busy}, 3'b000);
      reg_rd(8'hf0, rv);
      cmd(OP_SECTOR_ERASE, 1'b0);
      repeat (10) @(posedge clk_i);
      `CHK(rises, 0);
      for (int i = 0; i < 5; i++) begin
         cmd(OP_WRITE_ENABLE, 1'b0);
         `CHK(write_enable_latch, 1'b1);
         cmd(ops[i], 1'b0);
         wait_busy(1'b1, 10);
         `CHK(kind, kinds[i]);
         `CHK(eaddr, bases[i]);
         stat(s);
         `CHK(s[1:0], 2'b01);
         wait_busy(1'b0, 2000);
         `CHK(blen >= lens[i] && blen <= lens[i] + 1, 1'b1);
         stat(s);
         `CHK(s[1:0], 2'b00);
      end
      // any protect bit guards every region here
      @(posedge clk_i);
      bp <= 5'h01;
      r0 = rises;
      for (int j = 0; j < 2; j++) begin
         cmd(OP_WRITE_ENABLE, 1'b0);
         cmd(j ? OP_CHIP_ERASE_A : OP_SECTOR_ERASE, 1'b0);
         repeat (10) @(posedge clk_i);
         `CHK(rises, r0);
      end
      @(posedge clk_i);
      bp <= 5'h00;
      cmd(OP_WRITE_ENABLE, 1'b0);
      cmd(OP_CHIP_ERASE_B, 1'b0);
      cmd(OP_DEEP_SLEEP, 1'b0);
      cmd(OP_WAKE_ID, 1'b0);
      `CHK({busy, sleep}, 2'b10);
      wait_busy(1'b0, 2000);
      `CHK(blen >= CHP && blen <= CHP + 1, 1'b1);
      `CHK(sleep, 1'b0);
      sleep_cycle();
      cmd(OP_WRITE_ENABLE, 1'b0);
      `CHK({write_enable_latch, sleep}, 2'b01);
      cmd(OP_WAKE_ID, 1'b0);
      repeat (WAKE + 10) @(posedge clk_i);
      `CHK(sleep, 1'b0);
      cmd(OP_WAKE_ID, 1'b1);
      reg_rd(REG_STATUS, rv);
      `CHK(rv[15:8], ID);
      sleep_cycle();
      cmd(OP_WAKE_ID, 1'b1);
      reg_rd(REG_STATUS, rv);
      `CHK(rv[15:8], ID);
      repeat (WAKE + 10) @(posedge clk_i);
      cmd(OP_WRITE_ENABLE, 1'b0);
      `CHK({write_enable_latch, sleep}, 2'b10);
      sleep_cycle();
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      `CHK({write_enable_latch, sleep}, 2'b00);
      stop_test();
   end
endmodule : sfe_tb
